// file: verilog/ddc_decoder.v
// Dual DAC serial command decoder top.
// Assumes the host drives cs_n, sclk, sdi asynchronously to clk.
`timescale 1ns/1ns
`include "ddc_map.vh"
module ddc_decoder #(
   parameter WORD_BITS = 16,
   parameter VAL_BITS = 10
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Serial link
   input wire cs_n,
   input wire sclk,
   input wire sdi,
   // Channel outputs
   output reg [VAL_BITS-1:0] channel_a_output,
   output reg [VAL_BITS-1:0] channel_b_output,
   output reg [1:0] channel_a_power,
   output reg [1:0] channel_b_power,
   // Status
   output reg [VAL_BITS-1:0] input_a_value,
   output reg [VAL_BITS-1:0] input_b_value,
   output reg word_seen
);
   // -----------------------------------------------------------------
   // Link input conditioning
   // -----------------------------------------------------------------
   wire cs_n_f;
   wire sclk_f;
   wire sdi_f;
   wire [WORD_BITS-1:0] word;
   wire word_vld;
   ddc_sync #(.RST_VAL(1'b1)) u_sync_cs (
      .clk(clk),
      .rst(rst),
      .din(cs_n),
      .dout_q(cs_n_f)
   );
   ddc_sync #(.RST_VAL(1'b0)) u_sync_sclk (
      .clk(clk),
      .rst(rst),
      .din(sclk),
      .dout_q(sclk_f)
   );
   ddc_sync #(.RST_VAL(1'b0)) u_sync_sdi (
      .clk(clk),
      .rst(rst),
      .din(sdi),
      .dout_q(sdi_f)
   );
   // -----------------------------------------------------------------
   // Shift register
   // -----------------------------------------------------------------
   ddc_shift #(.WORD_BITS(WORD_BITS)) u_shift (
      .clk(clk),
      .rst(rst),
      .cs_n(cs_n_f),
      .sclk(sclk_f),
      .sdi(sdi_f),
      .word_q(word),
      .word_vld_q(word_vld)
   );
   // -----------------------------------------------------------------
   // Field split
   // -----------------------------------------------------------------
   wire [3:0] cmd = word[`DDC_CMD_HI:`DDC_CMD_LO];
   wire [VAL_BITS-1:0] val = word[`DDC_VAL_HI:`DDC_VAL_LO];
   wire [1:0] sub = word[`DDC_SUB_HI:`DDC_SUB_LO];
   wire [2:0] sel = word[`DDC_SEL_HI:`DDC_SEL_LO];
   // -----------------------------------------------------------------
   // Command execution
   // -----------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         input_a_value <= `DDC_VAL_RST;
         input_b_value <= `DDC_VAL_RST;
         channel_a_output <= `DDC_VAL_RST;
         channel_b_output <= `DDC_VAL_RST;
         channel_a_power <= `DDC_PWR_100K;
         channel_b_power <= `DDC_PWR_100K;
         word_seen <= 1'b0;
      end else begin
         word_seen <= word_vld;
         if (word_vld) begin
            case (cmd)
               `DDC_CMD_DIR_A: begin
                  channel_a_output <= val;
               end
               `DDC_CMD_DIR_B: begin
                  channel_b_output <= val;
               end
               `DDC_CMD_IN_A: begin
                  input_a_value <= val;
               end
               `DDC_CMD_IN_B: begin
                  input_b_value <= val;
               end
               `DDC_CMD_UPD_A: begin
                  channel_a_output <= input_a_value;
               end
               `DDC_CMD_UPD_B: begin
                  channel_b_output <= input_b_value;
               end
               `DDC_CMD_DIR_AB: begin
                  channel_a_output <= val;
                  channel_b_output <= val;
               end
               `DDC_CMD_IN_AB: begin
                  input_a_value <= val;
                  input_b_value <= val;
               end
               `DDC_CMD_UPD_AB: begin
                  channel_a_output <= input_a_value;
                  channel_b_output <= input_b_value;
               end
               `DDC_CMD_PWR: begin
                  case (sel)
                     `DDC_SEL_A: begin
                        channel_a_power <= sub;
                     end
                     `DDC_SEL_B: begin
                        channel_b_power <= sub;
                     end
                     `DDC_SEL_AB: begin
                        channel_a_power <= sub;
                        channel_b_power <= sub;
                     end
                     default: begin
                        channel_a_power <= channel_a_power;
                     end
                  endcase
               end
               default: begin
                  word_seen <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // ddc_decoder

// file: shared/ddc_map.vh
// Constants for the dual DAC serial command decoder.
// Assumes inclusion by bare name from any design file.
`ifndef DDC_MAP_VH
`define DDC_MAP_VH
// -----------------------------------------------------------------
// Word layout
// -----------------------------------------------------------------
`define DDC_WORD_BITS 16
`define DDC_CMD_HI 15
`define DDC_CMD_LO 12
`define DDC_VAL_HI 11
`define DDC_VAL_LO 2
`define DDC_SUB_HI 1
`define DDC_SUB_LO 0
// Channel select field inside the value field
`define DDC_SEL_HI 4
`define DDC_SEL_LO 2
// -----------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------
`define DDC_CMD_DIR_A 4'h0
`define DDC_CMD_DIR_B 4'h1
`define DDC_CMD_IN_A 4'h4
`define DDC_CMD_IN_B 4'h5
`define DDC_CMD_UPD_A 4'h8
`define DDC_CMD_UPD_B 4'h9
`define DDC_CMD_DIR_AB 4'hC
`define DDC_CMD_IN_AB 4'hD
`define DDC_CMD_UPD_AB 4'hE
`define DDC_CMD_PWR 4'hF
// Channel select codes for the power command
`define DDC_SEL_A 3'h0
`define DDC_SEL_B 3'h1
`define DDC_SEL_AB 3'h4
// -----------------------------------------------------------------
// Power states (sub_select_bits encoding)
// -----------------------------------------------------------------
`define DDC_PWR_ON 2'h0
`define DDC_PWR_FLOAT 2'h1
`define DDC_PWR_1K 2'h2
`define DDC_PWR_100K 2'h3
// Reset values
`define DDC_VAL_RST 10'h000
// Bit count at which a cut frame is still kept
`define DDC_KEEP_BITS 5'h0F
`endif

// file: verilog/ddc_sync.v
// Three-stage synchroniser with two-stage agreement filter.
// Assumes an asynchronous input and the block clock.
`timescale 1ns/1ns
module ddc_sync #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Raw and filtered level
   input wire din,
   output reg dout_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // Chain; first stage feeds only the second
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         dout_q <= RST_VAL;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout_q <= s3_q; // Change counts once stages agree
         end
      end
   end
endmodule // ddc_sync

// file: verilog/ddc_shift.v
// Serial shift register framed by chip select.
// Assumes synchronised, filtered link levels on the block clock.
`timescale 1ns/1ns
`include "ddc_map.vh"
module ddc_shift #(
   parameter WORD_BITS = 16
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Filtered link levels
   input wire cs_n,
   input wire sclk,
   input wire sdi,
   // Word out
   output reg [WORD_BITS-1:0] word_q,
   output reg word_vld_q
);
   reg sclk_d1_q;
   reg cs_n_d1_q;
   reg [4:0] cnt_q;
   reg [WORD_BITS-1:0] sh_q;
   reg done_q;
   wire fall = sclk_d1_q & ~sclk;
   wire cs_rise = ~cs_n_d1_q & cs_n;
   // Shift on falling serial clock, emit after 16 bits
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_d1_q <= 1'b0;
         cs_n_d1_q <= 1'b1;
         cnt_q <= 5'h00;
         sh_q <= {WORD_BITS{1'b0}};
         word_q <= {WORD_BITS{1'b0}};
         word_vld_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         sclk_d1_q <= sclk;
         cs_n_d1_q <= cs_n;
         word_vld_q <= 1'b0;
         if (cs_n) begin
            cnt_q <= 5'h00;
            done_q <= 1'b0;
         end else if (fall && !done_q) begin
            sh_q <= {sh_q[WORD_BITS-2:0], sdi};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == WORD_BITS - 1) begin
               word_q <= {sh_q[WORD_BITS-2:0], sdi};
               word_vld_q <= 1'b1;
               done_q <= 1'b1;
            end
         end
         if (cs_rise && !done_q && cnt_q == `DDC_KEEP_BITS) begin
            // Sixteenth edge lost to the rising select: keep the 15 clocks held
            word_q <= {sh_q[WORD_BITS-2:0], sdi};
            word_vld_q <= 1'b1;
         end
      end
   end
endmodule // ddc_shift

// file: dv/ddc_assertions.sv
// Checker for the decoder top: update timing and reset state.
// Assumes binding onto ddc_decoder with ports connected by name.
`timescale 1ns/1ns
module ddc_assertions #(
   parameter WORD_BITS = 16,
   parameter VAL_BITS = 10
) (
   // Clock, reset and link
   input wire clk,
   input wire rst,
   input wire cs_n,
   input wire sclk,
   input wire sdi,
   // Watched outputs
   input wire [VAL_BITS-1:0] channel_a_output,
   input wire [VAL_BITS-1:0] channel_b_output,
   input wire [1:0] channel_a_power,
   input wire [1:0] channel_b_power,
   input wire [VAL_BITS-1:0] input_a_value,
   input wire [VAL_BITS-1:0] input_b_value,
   input wire word_seen
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Idle link and quiet span after a word
   sequence s_idle; cs_n [*8]; endsequence
   sequence s_quiet; !word_seen [*8]; endsequence
   property p_rst; $fell(rst) |-> channel_a_power == 2'h3 && channel_b_power == 2'h3
      && channel_a_output == '0 && channel_b_output == '0 && input_a_value == '0
      && input_b_value == '0 && !word_seen; endproperty
   property p_out_a; $changed(channel_a_output) |-> word_seen; endproperty
   property p_out_b; $changed(channel_b_output) |-> word_seen; endproperty
   property p_in; $changed(input_a_value) || $changed(input_b_value) |-> word_seen; endproperty
   property p_pwr; $changed({channel_a_power, channel_b_power}) |-> word_seen; endproperty
   property p_pulse; word_seen |=> s_quiet; endproperty
   property p_frame; word_seen |-> !$past(cs_n, 8); endproperty
   property p_idle; s_idle |-> !word_seen; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_out_a: assert property (p_out_a) else $error("A moved alone");
   a_out_b: assert property (p_out_b) else $error("B moved alone");
   a_in: assert property (p_in) else $error("input moved alone");
   a_pwr: assert property (p_pwr) else $error("power moved alone");
   a_pulse: assert property (p_pulse) else $error("pulse too close");
   a_frame: assert property (p_frame) else $error("word off frame");
   a_idle: assert property (p_idle) else $error("word while idle");
endmodule // ddc_assertions

// file: dv/ddc_host.sv
// Host model: sends framed words on the three-wire link.
// Assumes the block clock; link clock stands still between frames.
`timescale 1ns/1ns
module ddc_host (
   // Clock
   input wire clk,
   // Link pins
   output reg cs_n,
   output reg sclk,
   output reg sdi
);
   integer i;
   // Idle levels at time zero
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      sdi = 1'b0;
   end
   // One frame of n bits, MSB first, 400 ns link period
   task send(input [15:0] w, input integer n);
      begin
         cs_n <= 1'b0;
         for (i = 15; i > 15 - n; i = i - 1) begin
            sdi <= w[i];
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
         end
         sdi <= ~sdi; // Hold time over
         cs_n <= 1'b1;
         repeat (8) @(posedge clk);
      end
   endtask
endmodule // ddc_host

// file: dv/ddc_decoder_bench.sv
// Self-checking bench for the decoder, host model on the link.
// Assumes the host model and checker files compiled before this one.
`timescale 1ns/1ns
module ddc_decoder_bench;
   reg clk;
   reg rst;
   wire cs_n, sclk, sdi, seen;
   wire [9:0] out_a, out_b, in_a, in_b;
   wire [1:0] pw_a, pw_b;
   integer err_total, n_tests, seed, cyc, k;
   reg [31:0] rnd;
   reg [7:0] seen_q;
   reg [51:0] exp_q;
   // Design and host
   ddc_decoder DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .channel_a_output(out_a), .channel_b_output(out_b), .channel_a_power(pw_a),
      .channel_b_power(pw_b), .input_a_value(in_a), .input_b_value(in_b), .word_seen(seen));
   ddc_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
   // Clock, word count and hang guard
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (seen === 1'b1) seen_q <= seen_q + 8'h01;
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         finish_test;
      end
   end
   // Expected state {inA, inB, dacA, dacB, pwrA, pwrB} after a word
   function [43:0] nxt(input [43:0] s, input [15:0] w);
      begin
         nxt = s;
         case (w[15:12])
            4'h0: nxt[23:14] = w[11:2];
            4'h1: nxt[13:4] = w[11:2];
            4'h4: nxt[43:34] = w[11:2];
            4'h5: nxt[33:24] = w[11:2];
            4'h8: nxt[23:14] = s[43:34];
            4'h9: nxt[13:4] = s[33:24];
            4'hC: nxt[23:4] = {2{w[11:2]}};
            4'hD: nxt[43:24] = {2{w[11:2]}};
            4'hE: nxt[23:4] = s[43:24];
            4'hF: begin
               if (w[4:2] == 3'h0 || w[4:2] == 3'h4) nxt[3:2] = w[1:0];
               if (w[4:2] == 3'h1 || w[4:2] == 3'h4) nxt[1:0] = w[1:0];
            end
            default: ;
         endcase
      end
   endfunction
   // Send a frame, advance expectations if it is kept
   // A 15-bit frame takes the released line, the inverse of bit 1, as bit 0
   task put(input [15:0] w, input integer n);
      begin
         if (n == 15) w[0] = ~w[1];
         u_host.send(w, n);
         if (n >= 15) exp_q = {exp_q[51:44] + 8'h01, nxt(exp_q[43:0], w)};
      end
   endtask
   // Compare word count and all state
   task chk;
      begin
         n_tests = n_tests + 1;
         if ({seen_q, in_a, in_b, out_a, out_b, pw_a, pw_b} !== exp_q) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: got %h exp %h", $time,
               {seen_q, in_a, in_b, out_a, out_b, pw_a, pw_b}, exp_q);
         end
      end
   endtask
   // Counts and verdict
   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, err_total);
         if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      err_total = 0;
      n_tests = 0;
      cyc = 0;
      seen_q = 8'h00;
      seed = 32'h4A0F;
      exp_q = 52'h0000000000000F;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk;
      $display("test reset done");
      for (k = 0; k < 32; k = k + 1) begin
         put({k[3:0], k[4] ? 12'hA52 : 12'h5A6}, 16);
         chk;
      end
      for (k = 0; k < 8; k = k + 1) begin
         put({4'hF, 7'h00, k[2], 2'h0, k[1:0]}, 16);
         chk;
      end
      $display("test codes done");
      put(16'h0155, 14);
      chk;
      put(16'hF010, 15);
      chk;
      $display("test cut frame done");
      for (k = 0; k < 40; k = k + 1) begin
         rnd = $random(seed);
         put(rnd[15:0], 16);
         chk;
      end
      $display("test random done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      exp_q = {exp_q[51:44], 44'h0000000000F};
      repeat (4) @(posedge clk);
      chk;
      $display("test second reset done");
      finish_test;
   end
endmodule // ddc_decoder_bench
bind ddc_decoder ddc_assertions #(.WORD_BITS(WORD_BITS), .VAL_BITS(VAL_BITS)) u_chk (
   .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
   .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
   .channel_a_power(channel_a_power), .channel_b_power(channel_b_power),
   .input_a_value(input_a_value), .input_b_value(input_b_value), .word_seen(word_seen));
